//--- dac_cmd_pkg.sv
// Package with the constants and types of the octal converter command port.
// Notes on behaviour
// (RULE1) While load strobe is low, every input register copies to its output register.
// (RULE2) Bits shift only with chip-select low; command executes on chip-select rise.
// (RULE3) Data input sampled into shift register on each rising shift-clock edge.
// (RULE4) Serial output changes on falling edge by default, rising edge after phase command.
// (RULE5) Reset clears interface, all channel registers to zero, falling-edge output timing.
// (RULE6) Frame is sixteen bits MSB first; first two bits ignored; full duplex.
// (RULE7) Frame decodes as 3-bit address, 3-bit opcode, eight data bits.
// (RULE8) Serial output shows each input bit sixteen shift-clock cycles later.
// (RULE9) Chip-select high: shift clock ignored, serial output holds, always driven.
// (RULE10) Host clocks exactly sixteen bits before raising chip-select.
// (RULE11) Host leaves shift clock low while pausing between frames.
// (RULE12) Frames in 4+4+8 bit groups or one word are treated alike.
// (RULE13) Opcode 000 changes nothing; bits only pass through.
// (RULE14) Opcode 001 clears all input and output registers.
// (RULE15) Opcode 010 enters shutdown; zero data bits disable channel buffers.
// (RULE16) Opcode 011 sets output phase from top address bit; held until changed.
// (RULE17) Opcode 100 loads data byte into all eight output registers; with load strobe low they take the input registers instead.
// (RULE18) Opcode 101 writes data byte into addressed input register only.
// (RULE19) Opcode 110 writes data byte into addressed input and output registers.
// (RULE20) Opcode 111 copies all input registers into output registers.
// (RULE21) With load strobe low, input writes appear on outputs at once.
// (RULE22) Both phase commands also copy all input registers to outputs.
// (RULE23) Output lag is 16.5 cycles in falling mode, 16 in rising mode.
// (RULE24) Clear, load-all and load-input-and-output commands end shutdown.
// (RULE25) Frames with fewer than sixteen rising edges are ignored.
// (RULE26) Bit counter resets whenever chip-select is high.
package dac_cmd_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 5;
   localparam int CHANNELS = 8;
   localparam int CODE_W = 8;
   localparam int ADDR_HI = 13;
   localparam int ADDR_LO = 11;
   localparam int OP_HI = 10;
   localparam int OP_LO = 8;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [7:0] BUF_ENABLED = 8'hFF;
   localparam logic [4:0] FULL_COUNT = 5'h10;
   typedef enum logic [2:0] {
      OP_IDLE, OP_CLEAR, OP_SHUTDOWN, OP_PHASE, OP_LOAD_ALL, OP_LOAD_INPUT,
      OP_LOAD_BOTH, OP_SW_LOAD
   } opcode_t;
endpackage

//--- edge_sync.sv
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module edge_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r, meta_nxt;
   logic sync_r, sync_nxt;
   logic last_r, last_nxt;
   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
      last_nxt = sync_r;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         last_r <= last_nxt;
      end
   end
   assign level = sync_r;
   assign rise = sync_r & ~last_r;
   assign fall = ~sync_r & last_r;
endmodule

//--- channel_bank.sv
// Double-buffered input and output registers of the eight channels.
`timescale 1ns/1ps
module channel_bank
   import dac_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load_strobe,
   input wire logic exec,
   input wire logic [2:0] opcode,
   input wire logic [2:0] addr,
   input wire logic [7:0] code_byte,
   output logic [CHANNELS*CODE_W-1:0] out_flat
);
   logic [CODE_W-1:0] in_r [CHANNELS];
   logic [CODE_W-1:0] in_nxt [CHANNELS];
   logic [CODE_W-1:0] out_r [CHANNELS];
   logic [CODE_W-1:0] out_nxt [CHANNELS];
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         in_nxt[i] = in_r[i];
         out_nxt[i] = out_r[i];
         if (exec) begin
            case (opcode_t'(opcode))
               OP_CLEAR: begin
                  in_nxt[i] = CODE_RESET; // [RULE14]
                  out_nxt[i] = CODE_RESET;
               end
               OP_PHASE: out_nxt[i] = in_r[i]; // [RULE22]
               OP_LOAD_ALL: out_nxt[i] = code_byte; // [RULE17]
               OP_LOAD_INPUT: begin
                  if (addr == i[2:0]) begin
                     in_nxt[i] = code_byte; // [RULE18]
                  end
               end
               OP_LOAD_BOTH: begin
                  if (addr == i[2:0]) begin
                     in_nxt[i] = code_byte; // [RULE19]
                     out_nxt[i] = code_byte;
                  end
               end
               OP_SW_LOAD: out_nxt[i] = in_r[i]; // [RULE20]
               default: begin
                  in_nxt[i] = in_r[i]; // [RULE13]
               end
            endcase
         end
         if (load_strobe) begin
            out_nxt[i] = in_nxt[i]; // [RULE1] [RULE21]
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            in_r[i] <= CODE_RESET; // [RULE5]
            out_r[i] <= CODE_RESET;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            in_r[i] <= in_nxt[i];
            out_r[i] <= out_nxt[i];
         end
      end
   end
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         out_flat[i*CODE_W +: CODE_W] = out_r[i];
      end
   end
endmodule

//--- octal_dac_serial_command_port.sv
// Top level of the serial command port of the eight-channel converter.
`timescale 1ns/1ps
module octal_dac_serial_command_port
   import dac_cmd_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic DIN,
   input wire logic LOAD_STROBE_N,
   output logic DOUT,
   output logic [7:0] CHANNEL_A_OUTPUT,
   output logic [7:0] CHANNEL_B_OUTPUT,
   output logic [7:0] CHANNEL_C_OUTPUT,
   output logic [7:0] CHANNEL_D_OUTPUT,
   output logic [7:0] CHANNEL_E_OUTPUT,
   output logic [7:0] CHANNEL_F_OUTPUT,
   output logic [7:0] CHANNEL_G_OUTPUT,
   output logic [7:0] CHANNEL_H_OUTPUT,
   output logic [7:0] BUFFER_ENABLE,
   output logic RISING_PHASE
);
   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   logic cs_lvl, cs_rise, sclk_rise, sclk_fall, din_lvl, ld_lvl;
   edge_sync cs_sync (
      .clk(MCLK), .rst_n(RESETN), .async_in(CS_N),
      .level(cs_lvl), .rise(cs_rise), .fall()
   );
   edge_sync sclk_sync (
      .clk(MCLK), .rst_n(RESETN), .async_in(SCLK),
      .level(), .rise(sclk_rise), .fall(sclk_fall)
   );
   edge_sync din_sync (
      .clk(MCLK), .rst_n(RESETN), .async_in(DIN),
      .level(din_lvl), .rise(), .fall()
   );
   edge_sync ld_sync (
      .clk(MCLK), .rst_n(RESETN), .async_in(LOAD_STROBE_N),
      .level(ld_lvl), .rise(), .fall()
   );

   // ****************************************************************
   // Shift register, bit counter and serial output.
   // ****************************************************************
   logic [FRAME_BITS-1:0] shift_r, shift_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic tail_r, tail_nxt;
   logic dout_r, dout_nxt;
   logic phase_r, phase_nxt;
   logic [7:0] buf_r, buf_nxt;
   logic exec;
   logic [CHANNELS*CODE_W-1:0] chan_flat;
   logic [2:0] op_w;

   assign op_w = shift_r[OP_HI:OP_LO]; // [RULE7]
   assign exec = cs_rise && (count_r >= FULL_COUNT); // [RULE2] [RULE25]

   always_comb begin
      shift_nxt = shift_r;
      count_nxt = count_r;
      tail_nxt = tail_r;
      dout_nxt = dout_r;
      if (cs_lvl) begin
         count_nxt = '0; // [RULE26] [RULE9]
      end else begin
         if (sclk_rise) begin
            tail_nxt = shift_r[FRAME_BITS-1]; // [RULE8]
            shift_nxt = {shift_r[FRAME_BITS-2:0], din_lvl}; // [RULE3] [RULE6] [RULE12]
            if (count_r < FULL_COUNT) begin
               count_nxt = count_r + 5'h01;
            end
            if (phase_r) begin
               dout_nxt = shift_r[FRAME_BITS-1]; // [RULE4] [RULE23]
            end
         end
         if (sclk_fall && !phase_r) begin
            dout_nxt = tail_r; // [RULE4] [RULE23]
         end
      end
   end

   // ****************************************************************
   // Mode state: output phase and buffer enables.
   // ****************************************************************
   always_comb begin
      phase_nxt = phase_r;
      buf_nxt = buf_r;
      if (exec) begin
         case (opcode_t'(op_w))
            OP_PHASE: phase_nxt = shift_r[ADDR_HI]; // [RULE16]
            OP_SHUTDOWN: buf_nxt = shift_r[7:0]; // [RULE15]
            OP_CLEAR, OP_LOAD_ALL, OP_LOAD_BOTH: buf_nxt = BUF_ENABLED; // [RULE24]
            default: buf_nxt = buf_r;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         shift_r <= '0; // [RULE5]
         count_r <= '0;
         tail_r <= 1'b0;
         dout_r <= 1'b0;
         phase_r <= 1'b0;
         buf_r <= BUF_ENABLED;
      end else begin
         shift_r <= shift_nxt;
         count_r <= count_nxt;
         tail_r <= tail_nxt;
         dout_r <= dout_nxt;
         phase_r <= phase_nxt;
         buf_r <= buf_nxt;
      end
   end

   // ****************************************************************
   // Channel registers.
   // ****************************************************************
   channel_bank bank (
      .clk(MCLK),
      .rst_n(RESETN),
      .load_strobe(~ld_lvl),
      .exec(exec),
      .opcode(op_w),
      .addr(shift_r[ADDR_HI:ADDR_LO]),
      .code_byte(shift_r[7:0]),
      .out_flat(chan_flat)
   );

   assign DOUT = dout_r;
   assign RISING_PHASE = phase_r;
   assign BUFFER_ENABLE = buf_r;
   assign CHANNEL_A_OUTPUT = chan_flat[7:0];
   assign CHANNEL_B_OUTPUT = chan_flat[15:8];
   assign CHANNEL_C_OUTPUT = chan_flat[23:16];
   assign CHANNEL_D_OUTPUT = chan_flat[31:24];
   assign CHANNEL_E_OUTPUT = chan_flat[39:32];
   assign CHANNEL_F_OUTPUT = chan_flat[47:40];
   assign CHANNEL_G_OUTPUT = chan_flat[55:48];
   assign CHANNEL_H_OUTPUT = chan_flat[63:56];
endmodule

//--- dac_port_asserts.sv
// Checker of the command port outputs.
`timescale 1ns/1ps
module dac_port_asserts (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CS_N,
   input wire logic LOAD_STROBE_N,
   input wire logic DOUT,
   input wire logic [7:0] CHANNEL_A_OUTPUT,
   input wire logic [7:0] CHANNEL_H_OUTPUT,
   input wire logic [7:0] BUFFER_ENABLE,
   input wire logic RISING_PHASE
);
   logic [3:0] cs_age_r, cs_age_nxt, ld_age_r, ld_age_nxt;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   // Ages count the cycles since chip-select or the strobe was last low.
   always_comb begin
      cs_age_nxt = CS_N ? cs_age_r + {3'h0, cs_age_r != 4'hF} : 4'h0;
      ld_age_nxt = LOAD_STROBE_N ? ld_age_r + {3'h0, ld_age_r != 4'hF} : 4'h0;
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         cs_age_r <= 4'hF;
         ld_age_r <= 4'hF;
      end else begin
         cs_age_r <= cs_age_nxt;
         ld_age_r <= ld_age_nxt;
      end
   end
   sequence s_idle; CS_N [*8]; endsequence
   sequence s_settled; (CS_N && !LOAD_STROBE_N) [*8]; endsequence
   property p_reset_vals; $rose(RESETN) |-> {CHANNEL_A_OUTPUT, BUFFER_ENABLE} == 16'h00FF; endproperty
   property p_dout_idle; s_idle |=> $stable(DOUT); endproperty
   property p_dout_quiet; !$stable(DOUT) |-> cs_age_r < 4'h6; endproperty
   property p_phase_quiet; $changed(RISING_PHASE) |-> cs_age_r > 4'h1 && cs_age_r < 4'h9; endproperty
   property p_buf_quiet; !$stable(BUFFER_ENABLE) |-> CS_N && $past(CS_N, 2); endproperty
   property p_a_quiet; !$stable(CHANNEL_A_OUTPUT) |-> CS_N || ld_age_r < 4'h8; endproperty
   property p_h_quiet; !$stable(CHANNEL_H_OUTPUT) |-> CS_N || ld_age_r < 4'h8; endproperty
   property p_settled; s_settled |=> $stable(CHANNEL_H_OUTPUT); endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
   a_dout_idle: assert property (p_dout_idle) else $error("idle output moved");
   a_dout_quiet: assert property (p_dout_quiet) else $error("output moved late");
   a_phase_quiet: assert property (p_phase_quiet) else $error("phase moved");
   a_buf_quiet: assert property (p_buf_quiet) else $error("enable moved");
   a_a_quiet: assert property (p_a_quiet) else $error("channel a moved");
   a_h_quiet: assert property (p_h_quiet) else $error("channel h moved");
   a_settled: assert property (p_settled) else $error("strobe copy unsettled");
endmodule
bind octal_dac_serial_command_port dac_port_asserts i_dac_port_asserts (.MCLK(MCLK),
   .RESETN(RESETN), .CS_N(CS_N), .LOAD_STROBE_N(LOAD_STROBE_N), .DOUT(DOUT),
   .CHANNEL_A_OUTPUT(CHANNEL_A_OUTPUT), .CHANNEL_H_OUTPUT(CHANNEL_H_OUTPUT),
   .BUFFER_ENABLE(BUFFER_ENABLE), .RISING_PHASE(RISING_PHASE));

//--- host_model.sv
// Host model that sends command frames and captures the serial output.
`timescale 1ns/1ps
module host_model (
   input wire logic mclk,
   input wire logic dout,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // Split pauses after each 4-bit group with the clock low.
   task automatic send(input logic [15:0] w, input int n, input bit split,
                       output logic [15:0] got);
      got = 16'h0000;
      @(posedge mclk);
      cs_n <= 1'b0;
      din <= w[15];
      repeat (4) @(posedge mclk);
      for (int i = 15; i > 15 - n; i--) begin
         repeat (3) @(posedge mclk);
         sclk <= 1'b1;
         repeat (5) @(posedge mclk);
         got = {got[14:0], dout};
         sclk <= 1'b0;
         din <= (i > 16 - n) ? w[i - 1] : ~w[i];
         if (split && (i == 12 || i == 8)) begin
            repeat (8) @(posedge mclk);
         end
      end
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask
endmodule

//--- tb.sv
// Testbench of the serial command port.
`timescale 1ns/1ps
module tb;
   import dac_cmd_pkg::*;
   logic mclk, resetn, load_n, cs_n, sclk, din, dout, rph;
   logic [7:0] a, b, c, d, e, f, g, h, ben;
   logic [15:0] got, n1, p0;
   int err_total = 0;
   int total_checks = 0;
   octal_dac_serial_command_port i_octal_dac_serial_command_port (.MCLK(mclk), .RESETN(resetn),
      .CS_N(cs_n), .SCLK(sclk), .DIN(din), .LOAD_STROBE_N(load_n), .DOUT(dout),
      .CHANNEL_A_OUTPUT(a), .CHANNEL_B_OUTPUT(b), .CHANNEL_C_OUTPUT(c), .CHANNEL_D_OUTPUT(d),
      .CHANNEL_E_OUTPUT(e), .CHANNEL_F_OUTPUT(f), .CHANNEL_G_OUTPUT(g), .CHANNEL_H_OUTPUT(h),
      .BUFFER_ENABLE(ben), .RISING_PHASE(rph));
   host_model i_host_model (.mclk(mclk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
   function automatic logic [15:0] fr(input logic [2:0] ad, op, input logic [7:0] dt);
      return {2'b00, ad, op, dt};
   endfunction
   task automatic check(input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tx(input logic [15:0] w);
      i_host_model.send(w, 16, 1'b0, got);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic t_reset();
      check({a, h}, 16'h0000);
      check({ben, 7'h00, rph}, 16'hFF00);
   endtask
   task automatic t_load();
      tx(fr(3'h0, OP_LOAD_INPUT, 8'h5A));
      tx(fr(3'h7, OP_LOAD_INPUT, 8'hC3));
      check({a, h}, 16'h0000);
      tx(fr(3'h5, OP_SW_LOAD, 8'h00));
      check({a, h}, 16'h5AC3);
      tx(fr(3'h7, OP_LOAD_BOTH, 8'h3C));
      check({a, h}, 16'h5A3C);
   endtask
   task automatic t_all();
      i_host_model.send(fr(3'h0, OP_CLEAR, 8'h00), 8, 1'b0, got);
      check({a, h}, 16'h5A3C);
      tx(fr(3'h2, OP_LOAD_ALL, 8'h77));
      check({a, h}, 16'h7777);
      check({b, c}, 16'h7777);
      check({d, e}, 16'h7777);
      check({f, g}, 16'h7777);
      tx(fr(3'h6, OP_CLEAR, 8'hFF));
      check({a, h}, 16'h0000);
      tx(fr(3'h6, OP_SW_LOAD, 8'hFF));
      check({a, h}, 16'h0000);
   endtask
   task automatic t_shut();
      tx(fr(3'h0, OP_SHUTDOWN, 8'h0F));
      check(ben, 8'h0F);
      tx(fr(3'h2, OP_LOAD_BOTH, 8'h10));
      check({ben, h}, 16'hFF00);
      check({c, b}, 16'h1000);
   endtask
   task automatic t_phase();
      tx(fr(3'h0, OP_LOAD_INPUT, 8'h66));
      i_host_model.send(fr(3'h4, OP_PHASE, 8'h00), 16, 1'b1, got);
      check({a, 7'h00, rph}, 16'h6601);
      n1 = fr(3'h3, OP_IDLE, 8'hA5);
      tx(n1);
      check(got, fr(3'h4, OP_PHASE, 8'h00));
      check({a, h}, 16'h6600);
      p0 = fr(3'h3, OP_PHASE, 8'h5C);
      tx(p0);
      check({got[14:0], rph}, {n1[14:0], 1'b0});
      tx(fr(3'h0, OP_IDLE, 8'h00));
      check(got, {n1[0], p0[15:1]});
   endtask
   task automatic t_strobe();
      tx(fr(3'h0, OP_LOAD_INPUT, 8'h11));
      check(a, 8'h66);
      load_n <= 1'b0;
      repeat (10) @(posedge mclk);
      check(a, 8'h11);
      tx(fr(3'h0, OP_LOAD_INPUT, 8'h22));
      check(a, 8'h22);
      load_n <= 1'b1;
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #3000000;
      err_total++;
      close_out();
   end
   initial begin
      resetn = 1'b0;
      load_n = 1'b1;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_load();
      t_all();
      t_shut();
      t_phase();
      t_strobe();
      close_out();
   end
endmodule
